/* File: scfh_cfg.svh */
// constants of the sensor command frame handler
`ifndef SCFH_CFG_SVH
`define SCFH_CFG_SVH
// frame identifiers
`define SCFH_ID_FSET   8'h0c
`define SCFH_ID_FQRY   8'h0d
`define SCFH_ID_FREP   8'h0e
`define SCFH_ID_SLEEP  8'h0f
`define SCFH_ID_SAVED  8'h10
`define SCFH_ID_CNT    8'h11
`define SCFH_ID_SCORE  8'h12
`define SCFH_ID_CFGACK 8'h13
`define SCFH_ID_FACK   8'h14
`define SCFH_ID_SBEG   8'h15
`define SCFH_ID_SEND   8'h16
`define SCFH_ID_WAKE   8'h17
`define SCFH_ID_ASET   8'h18
`define SCFH_ID_AQRY   8'h19
`define SCFH_ID_AACK   8'h1a
`define SCFH_ID_AREP   8'h1b
`define SCFH_ID_SLPOK  8'h1c
`define SCFH_ID_REST   8'h1d
`define SCFH_ID_RACK   8'h1e
// filter query fixed bytes, tap limit
`define SCFH_QRY_BYTES 16'h0301
`define SCFH_TAP_MAX   6'h20
`define SCFH_TAP_BASE  9'h003
// acquisition payload length in bytes
`define SCFH_ACQ_LEN   9'h00a
// score substitutes (float32 of 179.8 and 99.99)
`define SCFH_F_ABORT   32'h4333cccd
`define SCFH_F_NA      32'h42c7fae1
// register offsets
`define SCFH_REG_CTRL  8'h00
`define SCFH_REG_ACQW  8'h04
`define SCFH_REG_SMPW  8'h08
`define SCFH_REG_PACE  8'h0c
`define SCFH_REG_STAT  8'h10
// control bits and reset values
`define SCFH_BIT_POLL  0
`define SCFH_BIT_FLUSH 1
`define SCFH_RST_POLL  1'b1
`define SCFH_RST_FLUSH 1'b0
// pacing tick: one millisecond at 50 ns clock
`define SCFH_TICK_NS   1000000
`define SCFH_CLK_NS    50
`define SCFH_TICK_CYC  (`SCFH_TICK_NS / `SCFH_CLK_NS)
// reply kinds, lowest index is sent first
`define SCFH_K_WAKE    0
`define SCFH_K_SLPOK   1
`define SCFH_K_SAVED   2
`define SCFH_K_CNT     3
`define SCFH_K_SCORE   4
`define SCFH_K_CFGACK  5
`define SCFH_K_FACK    6
`define SCFH_K_AACK    7
`define SCFH_K_AREP    8
`define SCFH_K_FREP    9
`define SCFH_K_RACK    10
`define SCFH_NKIND     11
`endif

/* File: scfh_pkg.sv */
// types of the sensor command frame handler
package scfh_pkg;
  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,
    ST_SEND   = 3'b010,
    ST_ASLEEP = 3'b100
  } scfh_state_t;
endpackage

/* File: scfh_frame_handler.sv */
// command frame handler: decode, replies, sleep/wake, stream pacing
`timescale 1ns/1ps
`include "scfh_cfg.svh"

// Operation
// - id 13 with bytes 3,1 queries filter
// - filter query answered by id 14
// - id 15 puts device to sleep
// - receive activity wakes device, sends id 23
// - save result id 16, 16-bit code
// - calibration point count sent as id 17
// - final point sends six-float score id 18
// - aborted 179.8, not applicable 99.99
// - tilt range is half larger span
// - config ack id 19, filter ack 20
// - id 21 starts paced continuous output
// - id 22 stops continuous output
// - id 24 sets mode, flush, two delays
// - true is polled; continuous survives power cycle; here reset always restores polled
// - flush flag clears taps each measurement
// - acquire delay spaces internal samples
// - sample delay spaces output sets; here the PACE register gap in ms spaces them
// - id 25 answered by 27, ack 26
// - sleep command confirmed by id 28
// - id 29 restores factory magnetic set
// - restore answered by id 30
module scfh_frame_handler #(
  parameter int TICK_CYC = `SCFH_TICK_CYC
) (
  input  logic         CLK,
  input  logic         RST,
  input  logic         RX_VALID,
  input  logic         RX_FIRST,
  input  logic [7:0]   RX_DATA,
  input  logic         RX_END,
  input  logic         RX_CRC_OK,
  input  logic         RXD_PIN,
  input  logic         TX_READY,
  output logic         TX_VALID,
  output logic         TX_FIRST,
  output logic         TX_LAST,
  output logic [7:0]   TX_DATA,
  output logic         TX_BREAK,
  output logic         SLEEP,
  input  logic         SAVE_DONE,
  input  logic         SAVE_ERR,
  input  logic         CAL_SAMPLE,
  input  logic [5:0]   CAL_COUNT,
  input  logic         CAL_DONE,
  input  logic         CAL_ABORT,
  input  logic         CAL_MAG,
  input  logic         CAL_ACC,
  input  logic [191:0] CAL_FIELDS,
  input  logic [31:0]  PITCH_SPAN,
  input  logic [31:0]  ROLL_SPAN,
  input  logic         CFG_SET_DONE,
  output logic         MAG_RESTORE,
  output logic         STREAM_ON,
  output logic         MEAS_REQ,
  input  logic         MEAS_SENT,
  output logic         POLLED,
  output logic         FLUSH,
  output logic [31:0]  ACQ_WAIT,
  input  logic [7:0]   REG_ADDR,
  input  logic [31:0]  REG_WDATA,
  input  logic         REG_WR,
  input  logic         REG_RD,
  output logic [31:0]  REG_RDATA
);

  scfh_pkg::scfh_state_t st_r;             // main state
  logic [`SCFH_NKIND-1:0] pend_r;          // replies waiting
  logic [`SCFH_NKIND-1:0] pend_nxt;
  logic [3:0]   kind_r;                    // reply being sent
  logic [8:0]   tidx_r;                    // byte index, 0 is id
  logic [8:0]   tlen_r;                    // payload length
  logic [7:0]   fid_r;                     // id of frame received
  logic [8:0]   pidx_r;                    // payload bytes so far
  logic [79:0]  shf_r;                     // last payload bytes
  logic [5:0]   tcnt_r;                    // taps in use
  logic [5:0]   tnew_r;                    // tap count being received
  logic [7:0]   taps_r [0:255];            // tap value bytes
  logic         poll_r;                    // polled mode flag
  logic         flush_r;                   // tap clear flag
  logic [31:0]  acqw_r;                    // inter sample wait
  logic [31:0]  smpw_r;                    // inter output wait
  logic [15:0]  pace_r;                    // output gap in ms
  logic         save_err_r;                // last save result
  logic [5:0]   cnt_r;                     // calibration points
  logic [191:0] score_r;                   // score payload
  logic         stream_r;                  // continuous output on
  logic         mwait_r;                   // measurement in flight
  logic [15:0]  gap_r;                     // ms left before next
  logic [14:0]  tick_r;                    // cycles within a ms
  logic         req_r;                     // measurement request
  logic         rest_r;                    // restore pulse
  logic         rxd_s1_r;                  // pin sync stage 1
  logic         rxd_s2_r;                  // pin sync stage 2
  logic [31:0]  rdata_r;                   // bus read data
  logic [7:0]   byte_nxt;                  // next byte to send
  logic [3:0]   pick;                      // first pending kind
  logic         good_end;                  // accepted frame end
  logic         tx_take;                   // byte handed over
  logic [31:0]  span_max;                  // larger tilt span

  ////////////////////////////////////////////////////////////////////
  // helpers

  // frame id of a reply kind
  function automatic logic [7:0] kind_id(input logic [3:0] k);
    unique case (k)
      4'd`SCFH_K_WAKE:   kind_id = `SCFH_ID_WAKE;
      4'd`SCFH_K_SLPOK:  kind_id = `SCFH_ID_SLPOK;
      4'd`SCFH_K_SAVED:  kind_id = `SCFH_ID_SAVED;
      4'd`SCFH_K_CNT:    kind_id = `SCFH_ID_CNT;
      4'd`SCFH_K_SCORE:  kind_id = `SCFH_ID_SCORE;
      4'd`SCFH_K_CFGACK: kind_id = `SCFH_ID_CFGACK;
      4'd`SCFH_K_FACK:   kind_id = `SCFH_ID_FACK;
      4'd`SCFH_K_AACK:   kind_id = `SCFH_ID_AACK;
      4'd`SCFH_K_AREP:   kind_id = `SCFH_ID_AREP;
      4'd`SCFH_K_FREP:   kind_id = `SCFH_ID_FREP;
      default:           kind_id = `SCFH_ID_RACK;
    endcase
  endfunction

  // score field: abort and not-applicable substitutes
  function automatic logic [31:0] fld(input logic [31:0] v,
                                      input logic used);
    if (CAL_ABORT)
      fld = `SCFH_F_ABORT;
    else if (!used)
      fld = `SCFH_F_NA;
    else
      fld = v;
  endfunction

  assign good_end = RX_END && RX_CRC_OK
                    && (st_r != scfh_pkg::ST_ASLEEP);
  assign tx_take  = TX_VALID && TX_READY;
  // positive floats order like unsigned words
  assign span_max = (PITCH_SPAN > ROLL_SPAN) ? PITCH_SPAN : ROLL_SPAN;

  // lowest pending kind wins the transmitter
  always_comb
  begin
    pick = 4'd0;
    for (int i = `SCFH_NKIND - 1; i >= 0; i--)
      if (pend_r[i])
        pick = 4'(i);
  end

  // payload byte at index tidx_r+1 of the current reply
  always_comb
  begin
    logic [8:0]  p;
    logic [79:0] aimg;                     // acquisition reply image
    p = tidx_r;
    aimg = {7'h00, poll_r, 7'h00, flush_r, acqw_r, smpw_r};
    byte_nxt = 8'h00;
    unique case (kind_r)
      4'd`SCFH_K_SAVED:
        byte_nxt = (p == 9'h001) ? {7'h00, save_err_r} : 8'h00;
      4'd`SCFH_K_CNT:
        byte_nxt = {2'b00, cnt_r};
      4'd`SCFH_K_SCORE:
        byte_nxt = score_r[8'(9'd23 - p) * 8 +: 8];
      4'd`SCFH_K_AREP:
        byte_nxt = aimg[8'(9'd9 - p) * 8 +: 8];
      4'd`SCFH_K_FREP:
        if (p == 9'h000)
          byte_nxt = 8'(`SCFH_QRY_BYTES >> 8);
        else if (p == 9'h001)
          byte_nxt = 8'(`SCFH_QRY_BYTES);
        else if (p == 9'h002)
          byte_nxt = {2'b00, tcnt_r};
        else
          byte_nxt = taps_r[8'(p - `SCFH_TAP_BASE)];
      default:
        byte_nxt = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // receive side

  // payload index and byte capture
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      fid_r  <= 8'h00;
      pidx_r <= 9'h000;
      shf_r  <= 80'h0;
      tnew_r <= 6'h00;
    end
    else if (RX_VALID && RX_FIRST)
    begin
      fid_r  <= RX_DATA;
      pidx_r <= 9'h000;
    end
    else if (RX_VALID)
    begin
      shf_r <= {shf_r[71:0], RX_DATA};
      if (pidx_r != 9'h1ff)
        pidx_r <= pidx_r + 9'h001;
      if (pidx_r == 9'h002)
        tnew_r <= RX_DATA[5:0];
    end
  end

  // tap bytes; a bad frame may leave them part written
  always_ff @(posedge CLK)
  begin
    if (RX_VALID && !RX_FIRST && fid_r == `SCFH_ID_FSET
        && pidx_r >= `SCFH_TAP_BASE && pidx_r < 9'h103)
      taps_r[8'(pidx_r - `SCFH_TAP_BASE)] <= RX_DATA;
  end

  // rx pin synchroniser for wake detection
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
    end
    else
    begin
      rxd_s1_r <= RXD_PIN;
      rxd_s2_r <= rxd_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // settings written by frames or by the register port

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      poll_r  <= `SCFH_RST_POLL;
      flush_r <= `SCFH_RST_FLUSH;
      acqw_r  <= 32'h0;
      smpw_r  <= 32'h0;
      pace_r  <= 16'h0;
      tcnt_r  <= 6'h00;
    end
    else
    begin
      if (REG_WR && REG_ADDR == `SCFH_REG_CTRL)
      begin
        poll_r  <= REG_WDATA[`SCFH_BIT_POLL];
        flush_r <= REG_WDATA[`SCFH_BIT_FLUSH];
      end
      if (REG_WR && REG_ADDR == `SCFH_REG_ACQW)
        acqw_r <= REG_WDATA;
      if (REG_WR && REG_ADDR == `SCFH_REG_SMPW)
        smpw_r <= REG_WDATA;
      if (REG_WR && REG_ADDR == `SCFH_REG_PACE)
        pace_r <= REG_WDATA[15:0];
      // a frame arriving with a bus write overrides it
      if (good_end && fid_r == `SCFH_ID_ASET
          && pidx_r == `SCFH_ACQ_LEN)
      begin
        poll_r  <= shf_r[72];
        flush_r <= shf_r[64];
        acqw_r  <= shf_r[63:32];
        smpw_r  <= shf_r[31:0];
      end
      if (good_end && fid_r == `SCFH_ID_FSET && tnew_r <= `SCFH_TAP_MAX)
        tcnt_r <= tnew_r;
    end
  end

  // calibration reports captured from the calibration engine
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      save_err_r <= 1'b0;
      cnt_r      <= 6'h00;
      score_r    <= 192'h0;
    end
    else
    begin
      if (SAVE_DONE)
        save_err_r <= SAVE_ERR;
      if (CAL_SAMPLE)
        cnt_r <= CAL_COUNT;
      if (CAL_DONE)
      begin
        score_r[191:160] <= fld(CAL_FIELDS[191:160], CAL_MAG);
        score_r[159:128] <= CAL_FIELDS[159:128];
        score_r[127:96]  <= fld(CAL_FIELDS[127:96], CAL_ACC);
        score_r[95:64]   <= fld(CAL_FIELDS[95:64], CAL_MAG);
        score_r[63:32]   <= fld(CAL_FIELDS[63:32], CAL_MAG);
        // halve by lowering the exponent; tiny spans read as zero
        score_r[31:0] <= fld((span_max[30:23] > 8'h01)
          ? {span_max[31], span_max[30:23] - 8'h01, span_max[22:0]}
          : 32'h0, CAL_MAG);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pending replies: a new event wins over the clear of its start

  always_comb
  begin
    pend_nxt = pend_r;
    if (st_r == scfh_pkg::ST_RUN && pend_r != '0)
      pend_nxt[pick] = 1'b0;
    if (st_r == scfh_pkg::ST_ASLEEP && !rxd_s2_r)
      pend_nxt[`SCFH_K_WAKE] = 1'b1;
    if (SAVE_DONE)
      pend_nxt[`SCFH_K_SAVED] = 1'b1;
    if (CAL_SAMPLE)
      pend_nxt[`SCFH_K_CNT] = 1'b1;
    if (CAL_DONE)
      pend_nxt[`SCFH_K_SCORE] = 1'b1;
    if (CFG_SET_DONE)
      pend_nxt[`SCFH_K_CFGACK] = 1'b1;
    if (good_end)
      unique case (fid_r)
        `SCFH_ID_FQRY:
          if (pidx_r == 9'h002 && shf_r[15:0] == `SCFH_QRY_BYTES)
            pend_nxt[`SCFH_K_FREP] = 1'b1;
        `SCFH_ID_SLEEP:
          pend_nxt[`SCFH_K_SLPOK] = 1'b1;
        `SCFH_ID_FSET:
          pend_nxt[`SCFH_K_FACK] = 1'b1;
        `SCFH_ID_ASET:
          pend_nxt[`SCFH_K_AACK] = 1'b1;
        `SCFH_ID_AQRY:
          pend_nxt[`SCFH_K_AREP] = 1'b1;
        `SCFH_ID_REST:
          pend_nxt[`SCFH_K_RACK] = 1'b1;
        default:
          pend_nxt = pend_nxt;
      endcase
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      pend_r <= '0;
    else
      pend_r <= pend_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // transmitter and sleep state

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      st_r     <= scfh_pkg::ST_RUN;
      kind_r   <= 4'd0;
      tidx_r   <= 9'h000;
      tlen_r   <= 9'h000;
      TX_VALID <= 1'b0;
      TX_FIRST <= 1'b0;
      TX_LAST  <= 1'b0;
      TX_DATA  <= 8'h00;
    end
    else
      unique case (st_r)
        scfh_pkg::ST_RUN:
          if (pend_r != '0)
          begin
            st_r     <= scfh_pkg::ST_SEND;
            kind_r   <= pick;
            tidx_r   <= 9'h000;
            TX_VALID <= 1'b1;
            TX_FIRST <= 1'b1;
            TX_DATA  <= kind_id(pick);
            unique case (pick)
              4'd`SCFH_K_SAVED: tlen_r <= 9'h002;
              4'd`SCFH_K_CNT:   tlen_r <= 9'h001;
              4'd`SCFH_K_SCORE: tlen_r <= 9'h018;
              4'd`SCFH_K_AREP:  tlen_r <= `SCFH_ACQ_LEN;
              4'd`SCFH_K_FREP:  tlen_r <= `SCFH_TAP_BASE + {tcnt_r, 3'b000};
              default:          tlen_r <= 9'h000;
            endcase
            TX_LAST  <= !(pick inside {4'd`SCFH_K_SAVED, 4'd`SCFH_K_CNT,
                        4'd`SCFH_K_SCORE, 4'd`SCFH_K_AREP,
                        4'd`SCFH_K_FREP});
          end
        scfh_pkg::ST_SEND:
          if (tx_take && TX_LAST)
          begin
            TX_VALID <= 1'b0;
            TX_LAST  <= 1'b0;
            TX_FIRST <= 1'b0;
            // sleep only once its confirmation is out
            st_r <= (kind_r == 4'd`SCFH_K_SLPOK)
                    ? scfh_pkg::ST_ASLEEP : scfh_pkg::ST_RUN;
          end
          else if (tx_take)
          begin
            TX_FIRST <= 1'b0;
            TX_DATA  <= byte_nxt;
            tidx_r   <= tidx_r + 9'h001;
            TX_LAST  <= (tidx_r + 9'h001 == tlen_r);
          end
        scfh_pkg::ST_ASLEEP:
          if (!rxd_s2_r)
            st_r <= scfh_pkg::ST_RUN;
        default:
          st_r <= scfh_pkg::ST_RUN;
      endcase
  end

  ////////////////////////////////////////////////////////////////////
  // continuous output pacing and restore pulse

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      stream_r <= 1'b0;
      mwait_r  <= 1'b0;
      gap_r    <= 16'h0;
      tick_r   <= 15'h0;
      req_r    <= 1'b0;
      rest_r   <= 1'b0;
    end
    else
    begin
      rest_r <= good_end && fid_r == `SCFH_ID_REST;
      if (good_end && fid_r == `SCFH_ID_SBEG && !poll_r)
        stream_r <= 1'b1;
      else if (poll_r || (good_end && fid_r == `SCFH_ID_SEND))
        stream_r <= 1'b0;
      // paused while asleep, resumes on wake if still continuous
      if (!stream_r || st_r == scfh_pkg::ST_ASLEEP)
      begin
        mwait_r <= 1'b0;
        gap_r   <= 16'h0;
        req_r   <= 1'b0;
      end
      else if (req_r)
        req_r <= 1'b0;
      else if (mwait_r)
      begin
        if (MEAS_SENT)
        begin
          mwait_r <= 1'b0;
          gap_r   <= pace_r;
          tick_r  <= 15'h0;
        end
      end
      else if (gap_r != 16'h0)
      begin
        tick_r <= tick_r + 15'h1;
        if (tick_r == 15'(TICK_CYC - 1))
        begin
          tick_r <= 15'h0;
          gap_r  <= gap_r - 16'h1;
        end
      end
      else
      begin
        req_r   <= 1'b1;
        mwait_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register read port

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      rdata_r <= 32'h0;
    else if (REG_RD)
      unique case (REG_ADDR)
        `SCFH_REG_CTRL: rdata_r <= {30'h0, flush_r, poll_r};
        `SCFH_REG_ACQW: rdata_r <= acqw_r;
        `SCFH_REG_SMPW: rdata_r <= smpw_r;
        `SCFH_REG_PACE: rdata_r <= {16'h0, pace_r};
        `SCFH_REG_STAT: rdata_r <= {16'h0, 2'b00, tcnt_r, 5'h00,
                          st_r == scfh_pkg::ST_ASLEEP, mwait_r, stream_r};
        default:        rdata_r <= 32'h0;
      endcase
  end

  assign REG_RDATA   = rdata_r;
  assign SLEEP       = st_r[2];                        // one-hot asleep bit
  assign TX_BREAK    = st_r[2];
  assign STREAM_ON   = stream_r;
  assign MEAS_REQ    = req_r;
  assign MAG_RESTORE = rest_r;
  assign POLLED      = poll_r;
  assign FLUSH       = flush_r;
  assign ACQ_WAIT    = acqw_r;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_sleep_out;
    tx_take && TX_LAST && kind_r == 4'd`SCFH_K_SLPOK;
  endsequence
  // accepted frame of one id, with an extra condition on its payload or on the mode
  sequence s_frame(logic [7:0] id, logic c);
    good_end && fid_r == id && c;
  endsequence

  AST_QUERY_REPLY: assert property (
    s_frame(`SCFH_ID_FQRY, pidx_r == 9'h002
    && shf_r[15:0] == `SCFH_QRY_BYTES) |=> pend_r[`SCFH_K_FREP]
    || (st_r == scfh_pkg::ST_SEND && kind_r == 4'd`SCFH_K_FREP))
    else $error("filter query not answered");
  AST_SLEEP_ENTRY: assert property (
    s_sleep_out |=> SLEEP && TX_BREAK && !TX_VALID)
    else $error("no sleep after confirmation");
  AST_WAKE: assert property (
    SLEEP && !rxd_s2_r |=> !SLEEP ##1 TX_VALID
    && TX_DATA == `SCFH_ID_WAKE)
    else $error("no wake confirmation");
  AST_SAVE_CODE: assert property (
    SAVE_DONE |=> save_err_r == $past(SAVE_ERR))
    else $error("save code not kept");
  AST_ABORT_SCORE: assert property (
    CAL_DONE && CAL_ABORT |=> score_r[191:160] == `SCFH_F_ABORT
    && score_r[31:0] == `SCFH_F_ABORT)
    else $error("aborted score wrong");
  AST_STREAM_ON: assert property (
    s_frame(`SCFH_ID_SBEG, !poll_r) |=> STREAM_ON)
    else $error("stream did not start");
  AST_STREAM_OFF: assert property (
    s_frame(`SCFH_ID_SEND, 1'b1) |=> !STREAM_ON ##1 !MEAS_REQ)
    else $error("stream did not stop");
  AST_CFG_ACK: assert property (
    CFG_SET_DONE |=> pend_r[`SCFH_K_CFGACK])
    else $error("config ack lost");
  AST_RESTORE: assert property (
    s_frame(`SCFH_ID_REST, 1'b1) |=> MAG_RESTORE ##1 !MAG_RESTORE)
    else $error("restore pulse wrong");

endmodule

/* File: scfh_host.sv */
// host model: frames toward the handler, takes its reply bytes
`timescale 1ns/1ps
module scfh_host (
  input  logic       CLK,
  output logic       RX_VALID,
  output logic       RX_FIRST,
  output logic [7:0] RX_DATA,
  output logic       RX_END,
  output logic       RX_CRC_OK,
  output logic       RXD_PIN,
  output logic       TX_READY,
  input  logic       TX_VALID,
  input  logic       TX_FIRST,
  input  logic       TX_LAST,
  input  logic [7:0] TX_DATA
);
  logic [7:0] q[$]; // reply bytes taken so far
  logic       got;  // last byte of a reply taken
  int         nf;   // bytes taken flagged as first
  initial
  begin
    {RX_VALID, RX_FIRST, RX_DATA, RX_END, RX_CRC_OK} = '0;
    RXD_PIN = 1'b1;
    TX_READY = 1'b0;
    got = 1'b0;
    nf = 0;
  end
  // random stalls, so reply bytes must hold until taken
  always @(posedge CLK)
  begin
    TX_READY <= 1'($urandom_range(1));
    if (TX_VALID && TX_READY)
    begin
      q.push_back(TX_DATA);
      nf += int'(TX_FIRST);
      if (TX_LAST)
        got <= 1'b1;
    end
  end
  // one frame: id first, then payload, then end with checksum verdict
  task automatic send(input logic [7:0] f[$], input logic ok);
    foreach (f[i])
    begin
      @(posedge CLK);
      RX_VALID <= 1'b1;
      RX_FIRST <= (i == 0);
      RX_DATA <= f[i];
    end
    @(posedge CLK);
    {RX_VALID, RX_FIRST} <= 2'b00;
    RX_END <= 1'b1;
    RX_CRC_OK <= ok;
    @(posedge CLK);
    RX_END <= 1'b0;
  endtask
  // a short low on the line wakes the device; the break byte it sent
  // while asleep never reaches this byte level, so nothing to drop
  task automatic wake();
    @(posedge CLK);
    RXD_PIN <= 1'b0;
    repeat (4) @(posedge CLK);
    RXD_PIN <= 1'b1;
  endtask
endmodule

/* File: tb_scfh_frame_handler.sv */
// self-checking bench of the command frame handler
`timescale 1ns/1ps
module tb_scfh_frame_handler;
  typedef logic [7:0] scfh_bq_t[$]; // byte list of one frame
  logic CLK, RST, SAVE_DONE, SAVE_ERR, CAL_SAMPLE, CAL_DONE, CAL_ABORT;
  logic CAL_MAG, CAL_ACC, CFG_SET_DONE, MEAS_SENT, REG_WR, REG_RD;
  logic [5:0]   CAL_COUNT;
  logic [191:0] CAL_FIELDS;
  logic [31:0]  PITCH_SPAN, ROLL_SPAN, REG_WDATA, REG_RDATA, ACQ_WAIT;
  logic [7:0]   REG_ADDR, RX_DATA, TX_DATA;
  logic RX_VALID, RX_FIRST, RX_END, RX_CRC_OK, RXD_PIN, TX_READY;
  logic TX_VALID, TX_FIRST, TX_LAST, TX_BREAK, SLEEP, MAG_RESTORE;
  logic STREAM_ON, MEAS_REQ, POLLED, FLUSH;
  int          errors, cmp_count, nrest; // counters
  logic [31:0] d, a, s;                  // read data, random floats
  scfh_bq_t    e;                        // frame bytes
  scfh_frame_handler #(.TICK_CYC(4)) scfh_frame_handler_i (.CLK, .RST,
    .RX_VALID, .RX_FIRST, .RX_DATA, .RX_END, .RX_CRC_OK, .RXD_PIN,
    .TX_READY, .TX_VALID, .TX_FIRST, .TX_LAST, .TX_DATA, .TX_BREAK,
    .SLEEP, .SAVE_DONE, .SAVE_ERR, .CAL_SAMPLE, .CAL_COUNT, .CAL_DONE,
    .CAL_ABORT, .CAL_MAG, .CAL_ACC, .CAL_FIELDS, .PITCH_SPAN, .ROLL_SPAN,
    .CFG_SET_DONE, .MAG_RESTORE, .STREAM_ON, .MEAS_REQ, .MEAS_SENT,
    .POLLED, .FLUSH, .ACQ_WAIT, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
    .REG_RDATA);
  scfh_host scfh_host_i (.CLK, .RX_VALID, .RX_FIRST, .RX_DATA, .RX_END,
    .RX_CRC_OK, .RXD_PIN, .TX_READY, .TX_VALID, .TX_FIRST, .TX_LAST,
    .TX_DATA);
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // restore pulses seen
  always @(posedge CLK)
    if (MAG_RESTORE === 1'b1)
      nrest++;
  ////////////////////////////////////////////////////////////////////
  // acquisition frame layout: mode, flush, two big-endian words
  function automatic scfh_bq_t acq(input logic [7:0] id, m, f,
                                   input logic [31:0] x, y);
    return '{id, m, f, x[31:24], x[23:16], x[15:8], x[7:0],
             y[31:24], y[23:16], y[15:8], y[7:0]};
  endfunction
  // score reply: abort fills all but reserved, else magnetic only with
  // the accel field not applicable and half the 40.0 roll span
  function automatic scfh_bq_t score(input logic ab);
    logic [31:0] v;
    scfh_bq_t    x;
    x = '{8'h12};
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 1) ? CAL_FIELDS[159:128] : ab ? 32'h4333cccd
        : (i == 2) ? 32'h42c7fae1 : (i == 5) ? 32'h41a00000
        : CAL_FIELDS[191 - 32 * i -: 32];
      for (int b = 3; b >= 0; b--)
        x.push_back(8'(v >> (8 * b)));
    end
    return x;
  endfunction
  task automatic chk(input logic [63:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t seen %h wanted %h", $time, got, exp);
    end
  endtask
  // waits, bounded, for a whole reply and compares it byte by byte
  task automatic reply(input scfh_bq_t x);
    int n;
    n = 0;
    while (scfh_host_i.got !== 1'b1 && n < 600)
    begin
      @(posedge CLK);
      n++;
    end
    chk(scfh_host_i.nf, 1);
    chk(scfh_host_i.q.size(), x.size());
    foreach (x[i]) chk(scfh_host_i.q[i], x[i]);
    scfh_host_i.q.delete();
    scfh_host_i.got = 1'b0;
    scfh_host_i.nf = 0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] v);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= ad;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 v = REG_RDATA;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= ad;
    REG_WDATA <= v;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic wait_req(input int lo);
    int n;
    for (n = 0; n < 200 && MEAS_REQ !== 1'b1; n++)
      @(posedge CLK);
    chk(MEAS_REQ, 1'b1);
    chk(n >= lo, 1'b1);
    @(posedge CLK);
    MEAS_SENT <= 1'b1;
    @(posedge CLK);
    MEAS_SENT <= 1'b0;
  endtask
  task summarize;
    $display("compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, far beyond the length of the tests
  initial
  begin
    #(50 * 30000);
    errors++;
    summarize;
  end
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    {RST, SAVE_DONE, SAVE_ERR, CAL_SAMPLE, CAL_DONE, CAL_ABORT} = 6'h20;
    {CAL_MAG, CAL_ACC, CFG_SET_DONE, MEAS_SENT, REG_WR, REG_RD} = '0;
    {CAL_COUNT, REG_ADDR, REG_WDATA} = '0;
    PITCH_SPAN = 32'h41a00000; // 20.0, the 40.0 roll span is larger
    ROLL_SPAN = 32'h42200000;
    {errors, cmp_count, nrest} = '0;
    void'($urandom(55880));
    CAL_FIELDS = {6{$urandom()}};
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    rd(8'h00, d);
    chk(d, 32'h1);
    rd(8'h44, d);
    chk(d, 32'h0);
    scfh_host_i.send('{8'h19}, 1'b1);
    reply(acq(8'h1b, 8'h01, 8'h00, 0, 0));
    wr(8'h00, 32'h2);
    rd(8'h00, d);
    chk({POLLED, FLUSH, d}, {2'b01, 32'h2});
    $display("test defaults done");
    // random acquisition settings, set then echoed
    a = $urandom();
    s = $urandom();
    scfh_host_i.send(acq(8'h18, 8'h00, 8'h01, a, s), 1'b1);
    reply('{8'h1a});
    chk({POLLED, FLUSH, ACQ_WAIT}, {2'b01, a});
    scfh_host_i.send('{8'h19}, 1'b1);
    reply(acq(8'h1b, 8'h00, 8'h01, a, s));
    $display("test acquisition done");
    // stream start, two sets 3 ms (12 cycles) apart, stop
    wr(8'h0c, 32'h3);
    rd(8'h0c, d);
    chk(d, 32'h3);
    scfh_host_i.send('{8'h15}, 1'b1);
    wait_req(0);
    wait_req(12);
    chk(STREAM_ON, 1'b1);
    scfh_host_i.send('{8'h16}, 1'b1);
    repeat (3) @(posedge CLK);
    chk(STREAM_ON, 1'b0);
    $display("test stream done");
    // event replies
    @(posedge CLK);
    SAVE_DONE <= 1'b1;
    SAVE_ERR <= 1'b1;
    @(posedge CLK);
    SAVE_DONE <= 1'b0;
    reply('{8'h10, 8'h00, 8'h01});
    CAL_SAMPLE <= 1'b1;
    CAL_COUNT <= 6'h20;
    @(posedge CLK);
    CAL_SAMPLE <= 1'b0;
    reply('{8'h11, 8'h20});
    CFG_SET_DONE <= 1'b1;
    @(posedge CLK);
    CFG_SET_DONE <= 1'b0;
    reply('{8'h13});
    // aborted score, then a magnetic only score
    for (int k = 1; k >= 0; k--)
    begin
      CAL_DONE <= 1'b1;
      CAL_ABORT <= 1'(k);
      CAL_MAG <= 1'(1 - k);
      @(posedge CLK);
      CAL_DONE <= 1'b0;
      reply(score(1'(k)));
    end
    $display("test events done");
    // filter set with four random taps, then query; bad checksum ignored
    e = '{8'h0c, 8'h03, 8'h01, 8'h04};
    repeat (32) e.push_back(8'($urandom()));
    scfh_host_i.send(e, 1'b1);
    reply('{8'h14});
    scfh_host_i.send('{8'h0d, 8'h03, 8'h01}, 1'b1);
    e[0] = 8'h0e;
    reply(e);
    scfh_host_i.send('{8'h19}, 1'b0);
    repeat (20) @(posedge CLK);
    chk(scfh_host_i.q.size(), 0);
    scfh_host_i.send('{8'h1d}, 1'b1);
    reply('{8'h1e});
    chk(nrest, 1);
    $display("test filter restore done");
    // sleep, then wake on line activity
    scfh_host_i.send('{8'h0f}, 1'b1);
    reply('{8'h1c});
    repeat (3) @(posedge CLK);
    chk({SLEEP, TX_BREAK}, 2'b11);
    scfh_host_i.wake();
    reply('{8'h17});
    chk(SLEEP, 1'b0);
    $display("test sleep done");
    summarize;
  end
endmodule
